// File: inc/pbw_defs.svh
// constants for the polling bit-check wake-up block: field positions, reset words, timing counts
// assumes a single 200 MHz clock that also serves as the base clock of the polling timer
`ifndef PBW_DEFS_SVH
`define PBW_DEFS_SVH

`define PBW_CLK_PERIOD_PS 5000
// operating word fields (12 bits)
`define PBW_OP_BAUD_LSB 10
`define PBW_OP_NCHK_LSB 8
`define PBW_OP_POUT 7
`define PBW_OP_SLEEP_LSB 2
`define PBW_OP_XSTD 1
`define PBW_OP_XTEMP 0
`define PBW_OP_RESET 12'h22c
// limit word fields (12 bits)
`define PBW_LIM_MIN_LSB 6
`define PBW_LIM_MAX_LSB 0
`define PBW_LIM_RESET 12'h398
// sleep timing
`define PBW_SLEEP_UNIT 1024
`define PBW_SLEEP_PARK 5'h1f
`define PBW_NAP_STRETCH_FACTOR_LONG 4'h8
`define PBW_NAP_STRETCH_FACTOR_NORM 4'h1
// start-up settle time in ns and its cycle count, rounded up
`define PBW_STARTUP_NS 1800
`define PBW_STARTUP_CYC ((`PBW_STARTUP_NS * 1000 + `PBW_CLK_PERIOD_PS - 1) / `PBW_CLK_PERIOD_PS)
// data conditioning counts, in scaled ticks
`define PBW_HOLD_IN_WIN 6
`define PBW_HOLD_OUT_WIN 10
`define PBW_MAX_LOW 80
// host register byte offsets and command / status bit positions
`define PBW_REG_OPERATING_CONFIG_REG 8'h00
`define PBW_REG_LIMIT 8'h04
`define PBW_REG_CMD 8'h08
`define PBW_REG_STATUS 8'h0c
`define PBW_CMD_OFF 0
`define PBW_CMD_PULL 1
`define PBW_ST_LEVEL 0
`define PBW_ST_WAKE 1

`endif

// File: inc/pbw_pkg.sv
// types shared by both ends of the polling bit-check wake-up link
// assumes pbw_defs.svh for the numeric constants
package pbw_pkg;

  // polling phases of the receiver controller
  typedef enum logic [2:0] {
    PBW_SLEEP = 3'h0,
    PBW_STARTUP = 3'h1,
    PBW_CHECK = 3'h2,
    PBW_RECEIVE = 3'h3,
    PBW_PARK = 3'h4
  } pbw_state_e;

  typedef logic [11:0] pbw_word_t;

endpackage

// File: inc/pbw_link_if.sv
// link between the receiver controller and the host: config words, off command, shared data line
// assumes an external pull-up on the data line; either end may pull it low
`timescale 1ns/1ps
interface pbw_link_if;
  pbw_pkg::pbw_word_t cfg_word;
  logic operating_config_reg_wr;
  logic limit_wr;
  logic off_cmd;
  logic dev_data_o;
  logic dev_data_oe;
  logic host_data_o;
  logic host_data_oe;
  logic data_level;

  // wired level: low whenever an enabled driver drives low
  assign data_level = !((dev_data_oe && !dev_data_o) || (host_data_oe && !host_data_o));

  modport dev (
    input cfg_word, operating_config_reg_wr, limit_wr, off_cmd, data_level,
    output dev_data_o, dev_data_oe
  );
  modport host (
    output cfg_word, operating_config_reg_wr, limit_wr, off_cmd, host_data_o, host_data_oe,
    input data_level
  );
endinterface

// File: hdl/pbw_tick_gen.sv
// scaled tick generator: one-cycle pulse every 8, 4, 2 or 1 base clocks
// assumes mclk is the base clock; band changes take effect at the next reload
`timescale 1ns/1ps
`include "pbw_defs.svh"
module pbw_tick_gen (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [1:0] baud_band_select,
  output logic tick
);
  import pbw_pkg::*;

  logic [2:0] cnt_r;
  logic tick_r;

  // reload value for each band: base clocks per scaled tick minus one
  function automatic logic [2:0] reload_of(input logic [1:0] band);
    case (band)
      2'h0: reload_of = 3'h7;
      2'h1: reload_of = 3'h3;
      2'h2: reload_of = 3'h1;
      default: reload_of = 3'h0;
    endcase
  endfunction

  // down counter, tick on wrap
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 3'h0;
      tick_r <= 1'b0;
    end else if (cnt_r == 3'h0) begin
      cnt_r <= reload_of(baud_band_select);
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r - 3'h1;
      tick_r <= 1'b0;
    end
  end

  assign tick = tick_r;
endmodule

// File: hdl/pbw_device.sv
// receiver polling controller: sleep / start-up / bit-check loop, receiving mode and data conditioning
// assumes dem_out is synchronous to mclk and mclk is the base clock of all polling timing
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "pbw_defs.svh"
module pbw_device #(
  parameter int SLEEP_UNIT = `PBW_SLEEP_UNIT,
  parameter int STARTUP_CYC = `PBW_STARTUP_CYC,
  parameter int HOLD_IN = `PBW_HOLD_IN_WIN,
  parameter int HOLD_OUT = `PBW_HOLD_OUT_WIN,
  parameter int MAX_LOW = `PBW_MAX_LOW
) (
  pbw_link_if.dev link,
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic dem_out,
  output logic sig_path_en,
  output logic receiving,
  output logic pout,
  output logic nap_stretch_conditional_bit,
  output pbw_pkg::pbw_state_e phase
);
  import pbw_pkg::*;

  pbw_word_t operating_config_reg_r;
  pbw_word_t limit_r;
  pbw_state_e state_r, state_nxt;
  logic [23:0] sleep_cnt_r;
  logic [15:0] start_cnt_r;
  logic [6:0] iv_cnt_r;
  logic [4:0] edge_cnt_r;
  logic armed_r;
  logic dem_tick_r;
  logic level_r;
  logic [7:0] hold_cnt_r;
  logic [7:0] low_cnt_r;
  logic low_lock_r;
  logic [6:0] run_cnt_r;
  logic path_en_r;
  logic recv_r;
  logic tick;

  logic [1:0] baud_band_select;
  logic [4:0] sleep_len;
  logic [5:0] lim_min;
  logic [5:0] lim_max;
  logic [3:0] nap_stretch_factor;
  logic [4:0] checks_needed;
  logic [23:0] sleep_target;
  logic edge_now;
  logic chk_fail;
  logic chk_good;
  logic chk_done;

  // field decode of the two configuration words
  assign baud_band_select = operating_config_reg_r[`PBW_OP_BAUD_LSB +: 2];
  assign sleep_len = operating_config_reg_r[`PBW_OP_SLEEP_LSB +: 5];
  assign lim_min = limit_r[`PBW_LIM_MIN_LSB +: 6];
  assign lim_max = limit_r[`PBW_LIM_MAX_LSB +: 6];
  assign nap_stretch_factor = (operating_config_reg_r[`PBW_OP_XSTD] || operating_config_reg_r[`PBW_OP_XTEMP]) ?
    `PBW_NAP_STRETCH_FACTOR_LONG : `PBW_NAP_STRETCH_FACTOR_NORM;

  // edge-to-edge checks per bit code, two per bit
  always_comb begin
    case (operating_config_reg_r[`PBW_OP_NCHK_LSB +: 2])
      2'h0: checks_needed = 5'h00;
      2'h1: checks_needed = 5'h06;
      2'h2: checks_needed = 5'h0c;
      default: checks_needed = 5'h12;
    endcase
  end

  assign sleep_target = 24'(sleep_len) * 24'(nap_stretch_factor) * 24'(SLEEP_UNIT);

  // interval inside the window: at least min, below max, i.e. at most max minus one
  function automatic logic in_window(input logic [6:0] cnt, input logic [5:0] lo, input logic [5:0] hi);
    in_window = (cnt >= {1'b0, lo}) && (cnt < {1'b0, hi});
  endfunction

  pbw_tick_gen pbw_tick_gen_inst (
    .mclk(mclk),
    .reset_n(reset_n),
    .baud_band_select(baud_band_select),
    .tick(tick)
  );

  // bit-check decisions, only taken on scaled ticks
  assign edge_now = tick && (dem_out != dem_tick_r);
  assign chk_fail = (state_r == PBW_CHECK) && tick &&
    ((edge_now && armed_r && !in_window(iv_cnt_r, lim_min, lim_max)) ||
     (!edge_now && (iv_cnt_r + 7'h1 >= {1'b0, lim_max})));
  assign chk_good = (state_r == PBW_CHECK) && edge_now && armed_r && in_window(iv_cnt_r, lim_min, lim_max);
  assign chk_done = chk_good && (edge_cnt_r + 5'h1 >= checks_needed);

  // polling sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PBW_SLEEP: begin
        if (sleep_len == `PBW_SLEEP_PARK) begin
          state_nxt = PBW_PARK;
        end else if (sleep_target == 24'h0 || sleep_cnt_r + 24'h1 >= sleep_target) begin
          state_nxt = PBW_STARTUP;
        end
      end
      PBW_PARK: begin
        if (sleep_len != `PBW_SLEEP_PARK) begin
          state_nxt = PBW_SLEEP;
        end
      end
      PBW_STARTUP: begin
        if (start_cnt_r >= 16'(STARTUP_CYC - 1) && (checks_needed != 5'h00 || tick)) begin
          // a direct jump to receive waits for a tick so the wake edge stays tick-aligned
          state_nxt = (checks_needed == 5'h00) ? PBW_RECEIVE : PBW_CHECK;
        end
      end
      PBW_CHECK: begin
        if (chk_fail) begin
          state_nxt = PBW_SLEEP;
        end else if (chk_done) begin
          state_nxt = PBW_RECEIVE;
        end
      end
      PBW_RECEIVE: begin
        if (link.off_cmd) begin
          state_nxt = PBW_SLEEP;
        end
      end
      default: state_nxt = PBW_SLEEP;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= PBW_SLEEP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // phase timers restart on every phase change
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_cnt_r <= 24'h0;
      start_cnt_r <= 16'h0;
    end else begin
      sleep_cnt_r <= (state_r == PBW_SLEEP && state_nxt == PBW_SLEEP) ? sleep_cnt_r + 24'h1 : 24'h0;
      start_cnt_r <= (state_r == PBW_STARTUP && state_nxt == PBW_STARTUP) ? start_cnt_r + 16'h1 : 16'h0;
    end
  end

  // configuration words; a host write wins over the hardware clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      operating_config_reg_r <= `PBW_OP_RESET;
      limit_r <= `PBW_LIM_RESET;
    end else begin
      if (link.operating_config_reg_wr) begin
        operating_config_reg_r <= link.cfg_word;
      end else if (chk_fail) begin
        operating_config_reg_r[`PBW_OP_XTEMP] <= 1'b0;
      end
      if (link.limit_wr) begin
        limit_r <= link.cfg_word;
      end
    end
  end

  // demodulator sampled on the scaled tick only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dem_tick_r <= 1'b1;
    end else if (tick) begin
      dem_tick_r <= dem_out;
    end
  end

  // interval counter and pass count; first edge only arms, start-up data never reaches here
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      iv_cnt_r <= 7'h0;
      edge_cnt_r <= 5'h0;
      armed_r <= 1'b0;
    end else if (state_r != PBW_CHECK) begin
      iv_cnt_r <= 7'h0;
      edge_cnt_r <= 5'h0;
      armed_r <= 1'b0;
    end else if (edge_now) begin
      iv_cnt_r <= 7'h0;
      armed_r <= 1'b1;
      if (chk_good) begin
        edge_cnt_r <= edge_cnt_r + 5'h1;
      end
    end else if (tick) begin
      iv_cnt_r <= iv_cnt_r + 7'h1;
    end
  end

  // data conditioning: wake edge, debounce hold, low-time limit
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      level_r <= 1'b1;
      hold_cnt_r <= 8'h0;
      low_cnt_r <= 8'h0;
      low_lock_r <= 1'b0;
      run_cnt_r <= 7'h0;
    end else if (state_r != PBW_RECEIVE) begin
      level_r <= 1'b1;
      low_lock_r <= 1'b0;
      low_cnt_r <= 8'h0;
      run_cnt_r <= 7'h0;
      hold_cnt_r <= 8'(HOLD_IN);
      if (state_nxt == PBW_RECEIVE) begin
        level_r <= 1'b0;
      end
    end else if (tick) begin
      if (run_cnt_r != 7'h7f) begin
        run_cnt_r <= run_cnt_r + 7'h1;
      end
      if (hold_cnt_r != 8'h0) begin
        hold_cnt_r <= hold_cnt_r - 8'h1;
      end
      if (dem_out) begin
        low_lock_r <= 1'b0;
      end
      low_cnt_r <= level_r ? 8'h0 : low_cnt_r + 8'h1;
      if (!level_r && low_cnt_r >= 8'(MAX_LOW - 1)) begin
        // stuck low: release and stay high until the input rises again
        level_r <= 1'b1;
        low_lock_r <= 1'b1;
        run_cnt_r <= 7'h0;
        hold_cnt_r <= 8'(HOLD_OUT);
      end else if (hold_cnt_r == 8'h0 && dem_out != level_r && !(low_lock_r && !dem_out)) begin
        level_r <= dem_out;
        run_cnt_r <= 7'h0;
        hold_cnt_r <= in_window(run_cnt_r + 7'h1, lim_min, lim_max) ? 8'(HOLD_IN) : 8'(HOLD_OUT);
      end
    end
  end

  // status outputs registered from the next phase
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      path_en_r <= 1'b0;
      recv_r <= 1'b0;
    end else begin
      path_en_r <= (state_nxt != PBW_SLEEP) && (state_nxt != PBW_PARK);
      recv_r <= (state_nxt == PBW_RECEIVE);
    end
  end

  // open-drain drive: only ever pulls low
  assign link.dev_data_o = 1'b0;
  assign link.dev_data_oe = !level_r;
  assign sig_path_en = path_en_r;
  assign receiving = recv_r;
  assign pout = operating_config_reg_r[`PBW_OP_POUT];
  assign nap_stretch_conditional_bit = operating_config_reg_r[`PBW_OP_XTEMP];
  assign phase = state_r;
endmodule

// File: hdl/pbw_host.sv
// host end: register port for software, drives config words and off command, watches the data line
// assumes the single-cycle register port of the system; read data valid the cycle after the strobe
`timescale 1ns/1ps
`include "pbw_defs.svh"
module pbw_host (
  pbw_link_if.host link,
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  import pbw_pkg::*;

  pbw_word_t cfg_r;
  pbw_word_t operating_config_reg_sh_r;
  pbw_word_t limit_sh_r;
  logic operating_config_reg_wr_r;
  logic limit_wr_r;
  logic off_r;
  logic pull_r;
  logic level_q_r;
  logic wake_r;
  logic [31:0] rdata_r;
  logic fall;

  // config word and one-cycle write/off pulses toward the receiver
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= 12'h000;
      operating_config_reg_sh_r <= `PBW_OP_RESET;
      limit_sh_r <= `PBW_LIM_RESET;
      operating_config_reg_wr_r <= 1'b0;
      limit_wr_r <= 1'b0;
      off_r <= 1'b0;
      pull_r <= 1'b0;
    end else begin
      operating_config_reg_wr_r <= wr && (addr == `PBW_REG_OPERATING_CONFIG_REG);
      limit_wr_r <= wr && (addr == `PBW_REG_LIMIT);
      off_r <= wr && (addr == `PBW_REG_CMD) && wdata[`PBW_CMD_OFF];
      if (wr && addr == `PBW_REG_OPERATING_CONFIG_REG) begin
        cfg_r <= wdata[11:0];
        operating_config_reg_sh_r <= wdata[11:0];
      end
      if (wr && addr == `PBW_REG_LIMIT) begin
        cfg_r <= wdata[11:0];
        limit_sh_r <= wdata[11:0];
      end
      if (wr && addr == `PBW_REG_CMD) begin
        pull_r <= wdata[`PBW_CMD_PULL];
      end
    end
  end

  // wake flag on a falling data edge; the set wins over a same-cycle clear
  assign fall = level_q_r && !link.data_level;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      level_q_r <= 1'b1;
      wake_r <= 1'b0;
    end else begin
      level_q_r <= link.data_level;
      if (fall) begin
        wake_r <= 1'b1;
      end else if (wr && addr == `PBW_REG_STATUS && wdata[`PBW_ST_WAKE]) begin
        wake_r <= 1'b0;
      end
    end
  end

  // read mux, one cycle latency; unmapped and idle cycles return zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 32'h0;
    end else if (rd) begin
      case (addr)
        `PBW_REG_OPERATING_CONFIG_REG: rdata_r <= {20'h0, operating_config_reg_sh_r};
        `PBW_REG_LIMIT: rdata_r <= {20'h0, limit_sh_r};
        `PBW_REG_CMD: rdata_r <= {30'h0, pull_r, 1'b0};
        `PBW_REG_STATUS: rdata_r <= {30'h0, wake_r, level_q_r};
        default: rdata_r <= 32'h0;
      endcase
    end else begin
      rdata_r <= 32'h0;
    end
  end

  assign link.cfg_word = cfg_r;
  assign link.operating_config_reg_wr = operating_config_reg_wr_r;
  assign link.limit_wr = limit_wr_r;
  assign link.off_cmd = off_r;
  assign link.host_data_o = 1'b0;
  assign link.host_data_oe = pull_r;
  assign rdata = rdata_r;
endmodule

// File: sim/pbw_link_asserts.sv
// checker for the polling wake-up link: link wires and device status ports
// assumes one mclk domain with asynchronous active-low reset_n
`timescale 1ns/1ps
`include "pbw_defs.svh"
module pbw_link_asserts #(
  parameter int MAX_LOW = `PBW_MAX_LOW
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic operating_config_reg_wr,
  input wire logic off_cmd,
  input wire logic dev_data_oe,
  input wire logic sig_path_en,
  input wire logic receiving,
  input wire logic nap_stretch_conditional_bit,
  input wire pbw_pkg::pbw_state_e phase
);
  import pbw_pkg::*;
  // slowest band has 8 clocks a tick, plus margin for hold and wake pull
  localparam int LOW_LIM = (MAX_LOW + 16) * 8;
  logic [15:0] low_cnt_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // run length of the device pulling the line low
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) low_cnt_r <= 16'h0;
    else if (dev_data_oe) low_cnt_r <= low_cnt_r + 16'h1;
    else low_cnt_r <= 16'h0;
  end

  path_off_asleep_a: assert property ((phase == PBW_SLEEP || phase == PBW_PARK) |-> !sig_path_en)
    else $error("signal path on while asleep");
  startup_entry_a: assert property ((phase == PBW_STARTUP && $past(phase) != PBW_STARTUP) |->
    $past(phase) == PBW_SLEEP) else $error("start-up not entered from sleep");
  check_entry_a: assert property ((phase == PBW_CHECK && $past(phase) != PBW_CHECK) |->
    $past(phase) == PBW_STARTUP) else $error("bit check not entered from start-up");
  wake_pull_a: assert property ($rose(receiving) |-> ##[0:1] dev_data_oe)
    else $error("no wake pull on receive entry");
  receive_holds_a: assert property ((receiving && !off_cmd) |=> receiving)
    else $error("receive left without off command");
  off_sleep_a: assert property ((receiving && off_cmd) |=> (!receiving && phase == PBW_SLEEP))
    else $error("off command did not return to sleep");
  fail_clear_a: assert property (($past(phase) == PBW_CHECK && phase == PBW_SLEEP && !$past(operating_config_reg_wr)) |->
    !nap_stretch_conditional_bit) else $error("stretch bit kept after failed check");
  clear_cause_a: assert property (($fell(nap_stretch_conditional_bit) && !$past(operating_config_reg_wr)) |->
    $past(phase) == PBW_CHECK) else $error("stretch bit cleared without failed check");
  park_stays_a: assert property ((phase == PBW_PARK && !operating_config_reg_wr && !$past(operating_config_reg_wr)) |=>
    phase == PBW_PARK) else $error("park left without new word");
  low_limit_a: assert property (low_cnt_r <= 16'(LOW_LIM))
    else $error("data held low too long");

  cover property ($rose(receiving));
  cover property (phase == PBW_PARK);
  cover property ($fell(nap_stretch_conditional_bit));
endmodule

// File: sim/polling_bitcheck_wakeup_bench.sv
// bench for both link ends: software register port and demodulated input stimulus
// assumes pbw_defs.svh; short sleep unit and start-up count keep the run brief
`timescale 1ns/1ps
`include "pbw_defs.svh"
module polling_bitcheck_wakeup_bench;
  import pbw_pkg::*;
  localparam int ML = `PBW_MAX_LOW;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic dem_out = 1'b0;
  logic [31:0] rdata;
  logic sig_path_en, receiving, pout, cond_bit;
  pbw_state_e phase;
  integer seed = 32'h099c3b68;
  int hp = 0;
  int ph_cnt = 0;
  int n_errors = 0;
  int compares = 0;
  logic [31:0] exp_q[$];

  pbw_link_if link();
  pbw_device #(.SLEEP_UNIT(4), .STARTUP_CYC(8), .MAX_LOW(ML)) pbw_device_inst (.link(link.dev), .mclk(mclk),
    .reset_n(reset_n), .dem_out(dem_out), .sig_path_en(sig_path_en), .receiving(receiving), .pout(pout),
    .nap_stretch_conditional_bit(cond_bit), .phase(phase));
  pbw_host pbw_host_inst (.link(link.host), .mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  pbw_link_asserts #(.MAX_LOW(ML)) pbw_link_asserts_inst (.mclk(mclk), .reset_n(reset_n),
    .operating_config_reg_wr(link.operating_config_reg_wr), .off_cmd(link.off_cmd), .dev_data_oe(link.dev_data_oe),
    .sig_path_en(sig_path_en), .receiving(receiving), .nap_stretch_conditional_bit(cond_bit), .phase(phase));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_st(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t status %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    rd <= 1'b0;
  endtask

  // bounded wait; sampled 1 ns after the edge so register updates have landed
  task automatic wait_ph(input pbw_state_e p, input int n);
    int i;
    i = 0;
    while (phase !== p && i < n) begin
      @(posedge mclk);
      #1;
      i++;
    end
    if (phase !== p) begin
      n_errors++;
      $display("CHECK FAILED %0t phase wait timed out", $time);
      test_done();
    end
  endtask

  // cycles spent asleep, counted from the edge that entered sleep
  task automatic sleep_len(output int n);
    n = 0;
    while (phase === PBW_SLEEP && n < 2000) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  // read data stand only in the cycle after the strobe, so look mid-cycle
  always @(posedge mclk) rd_q <= rd;
  always @(negedge mclk) begin
    if (rd_q) chk_rd(rdata, exp_q.pop_front());
  end

  // demodulated input: noise when hp is zero, frozen when negative, else a square wave
  // hp is looked at every cycle so a new period or a freeze takes hold at once
  always begin
    @(posedge mclk);
    ph_cnt = (hp > 0 && ph_cnt + 1 < hp) ? ph_cnt + 1 : 0;
    if (hp == 0) begin
      dem_out <= 1'($random(seed));
    end else if (hp > 0 && ph_cnt == 0) begin
      dem_out <= !dem_out;
    end
  end

  initial begin
    int n;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    rd_reg(`PBW_REG_STATUS, 32'h1);
    rd_reg(8'h10, 32'h0);
    rd_reg(`PBW_REG_OPERATING_CONFIG_REG, 32'h22c);
    rd_reg(`PBW_REG_LIMIT, 32'h398);
    wr_reg(`PBW_REG_LIMIT, 32'h318);
    // band c with bit-count code c; half period 14..18 ticks sits inside the window
    for (int c = 0; c < 4; c++) begin
      hp = (8 >> c) * (14 + {$random(seed)} % 5);
      wr_reg(`PBW_REG_OPERATING_CONFIG_REG, 32'(32'h085 | (c << 10) | (c << 8)));
      wr_reg(`PBW_REG_CMD, 32'h1);
      if (c > 0) begin
        wait_ph(PBW_SLEEP, 8);
        sleep_len(n);
        chk_st(32'(n), 32'h20);
      end
      wait_ph(PBW_RECEIVE, 6000);
      chk_st({30'h0, cond_bit, pout}, 32'h3);
    end
    // freeze the input after the square wave has settled
    hp = -1;
    repeat (20) @(posedge mclk);
    dem_out <= 1'b1;
    repeat (40) @(posedge mclk);
    rd_reg(`PBW_REG_STATUS, 32'h3);
    wr_reg(`PBW_REG_STATUS, 32'h2);
    rd_reg(`PBW_REG_STATUS, 32'h1);
    dem_out <= 1'b0;
    repeat (2) @(posedge mclk);
    dem_out <= 1'b1;
    repeat (2) @(posedge mclk);
    rd_reg(`PBW_REG_STATUS, 32'h2);
    repeat (30) @(posedge mclk);
    rd_reg(`PBW_REG_STATUS, 32'h3);
    dem_out <= 1'b0;
    repeat (30) @(posedge mclk);
    rd_reg(`PBW_REG_STATUS, 32'h2);
    repeat (100) @(posedge mclk);
    rd_reg(`PBW_REG_STATUS, 32'h3);
    // host pull: the line goes low under the host's own drive
    wr_reg(`PBW_REG_CMD, 32'h2);
    rd_reg(`PBW_REG_CMD, 32'h2);
    rd_reg(`PBW_REG_STATUS, 32'h2);
    wr_reg(`PBW_REG_CMD, 32'h0);
    hp = 0;
    repeat (300) @(posedge mclk);
    chk_st({27'h0, phase, receiving, sig_path_en}, {27'h0, PBW_RECEIVE, 2'h3});
    // too short an interval fails, clears the conditional bit, sleep falls back to 2*1*4
    wr_reg(`PBW_REG_OPERATING_CONFIG_REG, 32'hf89);
    hp = 4;
    wr_reg(`PBW_REG_CMD, 32'h1);
    wait_ph(PBW_CHECK, 300);
    wait_ph(PBW_SLEEP, 60);
    chk_st({31'h0, cond_bit}, 32'h0);
    sleep_len(n);
    chk_st(32'(n), 32'h8);
    // no edge at all fails at the upper limit; permanent bit gives 2*8*4
    hp = -1;
    wr_reg(`PBW_REG_OPERATING_CONFIG_REG, 32'hf8a);
    wait_ph(PBW_CHECK, 300);
    wait_ph(PBW_SLEEP, 40);
    sleep_len(n);
    chk_st(32'(n), 32'h40);
    hp = 0;
    wr_reg(`PBW_REG_OPERATING_CONFIG_REG, 32'hf7c);
    wait_ph(PBW_PARK, 400);
    repeat (300) @(posedge mclk);
    chk_st({28'h0, phase, pout}, {28'h0, PBW_PARK, 1'b0});
    wr_reg(`PBW_REG_OPERATING_CONFIG_REG, 32'hf84);
    wait_ph(PBW_CHECK, 100);
    test_done();
  end
endmodule
